// File: hdl/iord_regs.svh
`ifndef IORD_REGS_SVH
`define IORD_REGS_SVH
// Summary of operation
// - Bit set/clear only at I/O 0x00-0x1F
// - Bit test with skip in bit range
// - Status flags clear on written one
// - Bit operation touches only addressed bit
// - Port instructions use I/O 0x00-0x3F
// - Data space mirror at I/O plus 0x20
// - Port instructions reach only 64 locations
// - Extended range reachable by loads/stores only

// Address space limits
`define IORD_IO_OFFSET  8'h20
`define IORD_BIT_TOP    8'h1F
`define IORD_PORT_TOP   8'h3F
`define IORD_EXT_BASE   8'h60
`define IORD_DATA_TOP   8'hFF
`define IORD_RST_VAL    8'h00
`define IORD_ONE_HOT    8'h01
`define IORD_NONE       8'h00

// Register data-space addresses
`define IORD_PORT_B_PIN_INPUT    8'h23
`define IORD_PORT_B_DIRECTION    8'h24
`define IORD_PORT_B_OUTPUT       8'h25
`define IORD_PORT_C_PIN_INPUT    8'h26
`define IORD_PORT_C_DIRECTION    8'h27
`define IORD_PORT_C_OUTPUT       8'h28
`define IORD_PORT_D_PIN_INPUT    8'h29
`define IORD_PORT_D_DIRECTION    8'h2A
`define IORD_PORT_D_OUTPUT       8'h2B
`define IORD_TIMER0_EVENT_FLAGS  8'h35
`define IORD_TIMER1_EVENT_FLAGS  8'h36
`define IORD_TIMER2_EVENT_FLAGS  8'h37
`define IORD_PIN_CHANGE_FLAGS    8'h3B
`define IORD_EXTERNAL_IRQ_FLAGS  8'h3C
`define IORD_EXTERNAL_IRQ_MASK   8'h3D
`define IORD_SCRATCH_ZERO        8'h3E
`define IORD_NVM_DATA_CONTROL    8'h3F
`define IORD_NVM_DATA_BYTE       8'h40
`define IORD_NVM_ADDRESS_LOW     8'h41
`define IORD_NVM_ADDRESS_HIGH    8'h42
`define IORD_GENERAL_TIMER_CTRL  8'h43
`define IORD_TIMER0_CONTROL_A    8'h44
`define IORD_TIMER0_CONTROL_B    8'h45
`define IORD_TIMER0_COUNT        8'h46
`define IORD_TIMER0_COMPARE_A    8'h47
`define IORD_TIMER0_COMPARE_B    8'h48
`define IORD_SCRATCH_ONE         8'h4A
`define IORD_SCRATCH_TWO         8'h4B
`define IORD_SERIAL_PERIPH_CTRL  8'h4C
`define IORD_SERIAL_PERIPH_STAT  8'h4D
`define IORD_SERIAL_PERIPH_DATA  8'h4E
`define IORD_COMPARATOR_CTRL     8'h50
`define IORD_SLEEP_CONTROL       8'h53
`define IORD_RESET_CAUSE_FLAGS   8'h54
`define IORD_CORE_MISC_CONTROL   8'h55
`define IORD_SELF_PROGRAM_CTRL   8'h57
`define IORD_CORE_STATUS_FLAGS   8'h5F
`define IORD_WATCHDOG_CTRL       8'h60
`define IORD_CLOCK_DIVIDER       8'h61
`define IORD_MODULE_POWER_GATING 8'h64
`define IORD_OSCILLATOR_TRIM     8'h66
`define IORD_PIN_CHANGE_GROUP_EN 8'h68
`define IORD_EXTERNAL_IRQ_SENSE  8'h69
`define IORD_PIN_CHANGE_MASK0    8'h6B
`define IORD_PIN_CHANGE_MASK1    8'h6C
`define IORD_PIN_CHANGE_MASK2    8'h6D
`define IORD_TIMER0_IRQ_MASK     8'h6E
`define IORD_TIMER1_IRQ_MASK     8'h6F

// Implemented-bit masks
`define IORD_M_FULL  8'hFF
`define IORD_M_LOW2  8'h03
`define IORD_M_LOW3  8'h07
`define IORD_M_LOW4  8'h0F
`define IORD_M_LOW6  8'h3F
`define IORD_M_LOW7  8'h7F
`define IORD_M_TMR1  8'h27
`define IORD_M_GTC   8'h83
`define IORD_M_T0A   8'hF3
`define IORD_M_T0B   8'hCF
`define IORD_M_SPS   8'hC1
`define IORD_M_MISC  8'h73
`define IORD_M_SPM   8'hDF
`define IORD_M_CLK   8'h8F
`define IORD_M_PWR   8'hEF
`define IORD_W_CMP   8'h10
`endif

// File: hdl/iord_pkg.sv
package iord_pkg;
  // Access kinds; addressing mode of loads/stores does not matter here
  typedef enum logic [2:0] {
    iord_port_read          = 3'b000,
    iord_port_write         = 3'b001,
    iord_memory_read        = 3'b010,
    iord_memory_write       = 3'b011,
    iord_bit_set_op         = 3'b100,
    iord_bit_clear_op       = 3'b101,
    iord_skip_when_bit_high = 3'b110,
    iord_skip_when_bit_low  = 3'b111
  } iord_op_e;
  typedef struct packed {
    logic       valid;
    iord_op_e   op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iord_req_s;
  typedef struct packed {
    logic       ack;
    logic       refused;
    logic       skip;
    logic [7:0] rdata;
  } iord_resp_s;
  typedef struct packed {
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } iord_pins_s;
  typedef struct packed {
    logic [7:0] b_out;
    logic [7:0] b_dir;
    logic [7:0] c_out;
    logic [7:0] c_dir;
    logic [7:0] d_out;
    logic [7:0] d_dir;
  } iord_gpio_s;
  typedef struct packed {
    logic [7:0] timer0;
    logic [7:0] timer1;
    logic [7:0] timer2;
    logic [7:0] pin_change;
    logic [7:0] ext_irq;
    logic [7:0] comparator;
  } iord_evt_s;
endpackage : iord_pkg

// File: hdl/iord_top.sv
`timescale 1ns/1ps
`include "iord_regs.svh"
module iord_top (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // Core access request
  input  wire iord_pkg::iord_req_s req_i,
  // Peripheral events and pins
  input  wire iord_pkg::iord_evt_s events_i,
  input  wire iord_pkg::iord_pins_s pins_i,
  // Core access answer
  output      iord_pkg::iord_resp_s resp_o,
  // Port output and direction registers
  output      iord_pkg::iord_gpio_s gpio_o
);

  // Implemented bits of each address; zero marks a reserved location
  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    logic [7:0] m;
    m = `IORD_NONE;
    case (a)
      `IORD_PORT_B_PIN_INPUT,
      `IORD_PORT_B_DIRECTION,
      `IORD_PORT_B_OUTPUT,
      `IORD_PORT_D_PIN_INPUT,
      `IORD_PORT_D_DIRECTION,
      `IORD_PORT_D_OUTPUT,
      `IORD_NVM_DATA_BYTE,
      `IORD_NVM_ADDRESS_LOW,
      `IORD_NVM_ADDRESS_HIGH,
      `IORD_TIMER0_COUNT,
      `IORD_TIMER0_COMPARE_A,
      `IORD_TIMER0_COMPARE_B,
      `IORD_SCRATCH_ZERO,
      `IORD_SCRATCH_ONE,
      `IORD_SCRATCH_TWO,
      `IORD_SERIAL_PERIPH_CTRL,
      `IORD_SERIAL_PERIPH_DATA,
      `IORD_COMPARATOR_CTRL,
      `IORD_CORE_STATUS_FLAGS,
      `IORD_WATCHDOG_CTRL,
      `IORD_OSCILLATOR_TRIM,
      `IORD_PIN_CHANGE_MASK0,
      `IORD_PIN_CHANGE_MASK2: m = `IORD_M_FULL;
      `IORD_PORT_C_PIN_INPUT,
      `IORD_PORT_C_DIRECTION,
      `IORD_PORT_C_OUTPUT,
      `IORD_PIN_CHANGE_MASK1: m = `IORD_M_LOW7;
      `IORD_TIMER0_EVENT_FLAGS,
      `IORD_TIMER2_EVENT_FLAGS,
      `IORD_PIN_CHANGE_FLAGS,
      `IORD_PIN_CHANGE_GROUP_EN,
      `IORD_TIMER0_IRQ_MASK: m = `IORD_M_LOW3;
      `IORD_TIMER1_EVENT_FLAGS,
      `IORD_TIMER1_IRQ_MASK: m = `IORD_M_TMR1;
      `IORD_EXTERNAL_IRQ_FLAGS,
      `IORD_EXTERNAL_IRQ_MASK: m = `IORD_M_LOW2;
      `IORD_SLEEP_CONTROL,
      `IORD_RESET_CAUSE_FLAGS,
      `IORD_EXTERNAL_IRQ_SENSE: m = `IORD_M_LOW4;
      `IORD_NVM_DATA_CONTROL: m = `IORD_M_LOW6;
      `IORD_GENERAL_TIMER_CTRL: m = `IORD_M_GTC;
      `IORD_TIMER0_CONTROL_A: m = `IORD_M_T0A;
      `IORD_TIMER0_CONTROL_B: m = `IORD_M_T0B;
      `IORD_SERIAL_PERIPH_STAT: m = `IORD_M_SPS;
      `IORD_CORE_MISC_CONTROL: m = `IORD_M_MISC;
      `IORD_SELF_PROGRAM_CTRL: m = `IORD_M_SPM;
      `IORD_CLOCK_DIVIDER: m = `IORD_M_CLK;
      `IORD_MODULE_POWER_GATING: m = `IORD_M_PWR;
      default: m = `IORD_NONE;
    endcase
    return m;
  endfunction

  // Bits that clear on a written one and are set by hardware events
  function automatic logic [7:0] w1c_mask(input logic [7:0] a);
    logic [7:0] m;
    m = `IORD_NONE;
    case (a)
      `IORD_TIMER0_EVENT_FLAGS,
      `IORD_TIMER1_EVENT_FLAGS,
      `IORD_TIMER2_EVENT_FLAGS,
      `IORD_PIN_CHANGE_FLAGS,
      `IORD_EXTERNAL_IRQ_FLAGS: m = reg_mask(a);
      `IORD_COMPARATOR_CTRL: m = `IORD_W_CMP;
      default: m = `IORD_NONE;
    endcase
    return m;
  endfunction

  // Pin input registers follow the pins; software writes do not stick
  function automatic logic is_pin_reg(input logic [7:0] a);
    return (a == `IORD_PORT_B_PIN_INPUT) || (a == `IORD_PORT_C_PIN_INPUT)
        || (a == `IORD_PORT_D_PIN_INPUT);
  endfunction

  // Pin value feeding a pin input register
  function automatic logic [7:0] pin_for(input logic [7:0] a,
                                          input iord_pkg::iord_pins_s p);
    logic [7:0] v;
    v = `IORD_NONE;
    case (a)
      `IORD_PORT_B_PIN_INPUT: v = p.b;
      `IORD_PORT_C_PIN_INPUT: v = p.c;
      `IORD_PORT_D_PIN_INPUT: v = p.d;
      default: v = `IORD_NONE;
    endcase
    return v;
  endfunction

  // Hardware event bits feeding a flag register
  function automatic logic [7:0] evt_for(input logic [7:0] a,
                                          input iord_pkg::iord_evt_s e);
    logic [7:0] v;
    v = `IORD_NONE;
    case (a)
      `IORD_TIMER0_EVENT_FLAGS: v = e.timer0;
      `IORD_TIMER1_EVENT_FLAGS: v = e.timer1;
      `IORD_TIMER2_EVENT_FLAGS: v = e.timer2;
      `IORD_PIN_CHANGE_FLAGS: v = e.pin_change;
      `IORD_EXTERNAL_IRQ_FLAGS: v = e.ext_irq;
      `IORD_COMPARATOR_CTRL: v = e.comparator;
      default: v = `IORD_NONE;
    endcase
    return v;
  endfunction

  logic [7:0]           ea;       // Effective data-space address
  logic                 ea_ok;    // Request lies in its legal range
  logic                 is_wr;    // Request writes the register
  logic                 is_bit;   // Single-bit set or clear
  logic                 is_skip;  // Bit test with skip
  logic                 wr_go;    // Write takes effect this cycle
  logic [7:0]           wbits;    // Bits the write may touch
  logic [7:0]           wval;     // Value written into those bits
  logic [7:0]           rd;       // Read value, reserved bits zeroed
  logic [7:0]           mem_q [`IORD_IO_OFFSET:`IORD_DATA_TOP];
  iord_pkg::iord_resp_s resp_q;   // Registered answer

  // Address decode: each access kind has its own window
  always_comb begin
    ea      = req_i.addr;
    ea_ok   = 1'b0;
    is_wr   = 1'b0;
    is_bit  = 1'b0;
    is_skip = 1'b0;
    case (req_i.op)
      // Port forms see 64 locations, mirrored up by the offset
      iord_pkg::iord_port_read: begin
        ea    = req_i.addr + `IORD_IO_OFFSET;
        ea_ok = req_i.addr <= `IORD_PORT_TOP;
      end
      iord_pkg::iord_port_write: begin
        ea    = req_i.addr + `IORD_IO_OFFSET;
        ea_ok = req_i.addr <= `IORD_PORT_TOP;
        is_wr = 1'b1;
      end
      // Loads and stores alone reach the extended range
      iord_pkg::iord_memory_read: begin
        ea_ok = req_i.addr >= `IORD_IO_OFFSET;
      end
      iord_pkg::iord_memory_write: begin
        ea_ok = req_i.addr >= `IORD_IO_OFFSET;
        is_wr = 1'b1;
      end
      // Bit forms only touch the lowest 32 I/O locations
      iord_pkg::iord_bit_set_op,
      iord_pkg::iord_bit_clear_op: begin
        ea     = req_i.addr + `IORD_IO_OFFSET;
        ea_ok  = req_i.addr <= `IORD_BIT_TOP;
        is_wr  = 1'b1;
        is_bit = 1'b1;
      end
      iord_pkg::iord_skip_when_bit_high,
      iord_pkg::iord_skip_when_bit_low: begin
        ea      = req_i.addr + `IORD_IO_OFFSET;
        ea_ok   = req_i.addr <= `IORD_BIT_TOP;
        is_skip = 1'b1;
      end
      default: ea_ok = 1'b0;
    endcase
  end

  // Write strobe and data; a bit op drives only its one bit
  always_comb begin
    wr_go = req_i.valid && ea_ok && is_wr;
    wbits = is_bit ? (`IORD_ONE_HOT << req_i.bit_sel) : `IORD_M_FULL;
    if (req_i.op == iord_pkg::iord_bit_set_op) begin
      wval = wbits;
    end else if (req_i.op == iord_pkg::iord_bit_clear_op) begin
      wval = `IORD_NONE;
    end else begin
      wval = req_i.wdata;
    end
  end

  // Read path; reserved bits and locations read as zero
  always_comb begin
    rd = `IORD_NONE;
    if (ea_ok) begin
      rd = mem_q[ea] & reg_mask(ea);
    end
  end

  // One storage byte per data-space address; unmapped ones stay zero
  for (genvar i = `IORD_IO_OFFSET; i <= `IORD_DATA_TOP; i++) begin : g_reg
    localparam logic [7:0] A   = 8'(i);
    localparam logic [7:0] MSK = reg_mask(A);
    localparam logic [7:0] W1C = w1c_mask(A);
    localparam logic       PIN = is_pin_reg(A);
    logic [7:0] hit;  // Bits this write targets here
    logic [7:0] plain; // Ordinary bits after the write
    logic [7:0] flag;  // Flag bits after clear and set
    assign hit   = (wr_go && ea == A) ? wbits : `IORD_NONE;
    assign plain = (mem_q[i] & ~hit) | (wval & hit);
    // Set beats clear so an event in the clearing cycle survives
    assign flag  = (mem_q[i] & ~(wval & hit)) | evt_for(A, events_i);
    // Reserved bits and addresses never take a value
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        mem_q[i] <= `IORD_RST_VAL;
      end else if (PIN) begin
        mem_q[i] <= pin_for(A, pins_i) & MSK;
      end else begin
        mem_q[i] <= ((plain & ~W1C) | (flag & W1C)) & MSK;
      end
    end
  end

  // Answer one cycle after each request
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      resp_q <= '0;
    end else begin
      resp_q.ack     <= req_i.valid;
      // Out-of-window forms are refused and change nothing
      resp_q.refused <= req_i.valid && !ea_ok;
      resp_q.rdata   <= (req_i.valid && ea_ok && !is_wr) ? rd : `IORD_NONE;
      // Skip when the tested bit matches the requested sense
      resp_q.skip    <= req_i.valid && ea_ok && is_skip &&
                        (rd[req_i.bit_sel] ==
                         (req_i.op == iord_pkg::iord_skip_when_bit_high));
    end
  end

  assign resp_o = resp_q;
  assign gpio_o = '{b_out: mem_q[`IORD_PORT_B_OUTPUT],
                    b_dir: mem_q[`IORD_PORT_B_DIRECTION],
                    c_out: mem_q[`IORD_PORT_C_OUTPUT],
                    c_dir: mem_q[`IORD_PORT_C_DIRECTION],
                    d_out: mem_q[`IORD_PORT_D_OUTPUT],
                    d_dir: mem_q[`IORD_PORT_D_DIRECTION]};

  // Checks on the answers and the register file
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_bit_range: assert property (
    req_i.valid && is_bit && req_i.addr > `IORD_BIT_TOP
    |=> resp_q.refused && resp_q.ack)
    else $error("bit op outside low range accepted");

  a_skip_sense: assert property (
    req_i.valid && is_skip && ea_ok
    |=> resp_q.skip == ($past(rd[req_i.bit_sel]) ==
        ($past(req_i.op) == iord_pkg::iord_skip_when_bit_high)))
    else $error("skip answer does not match tested bit");

  // Both byte write forms reach the flags, so both are watched; a set
  // request in the same cycle is excluded since it must win
  a_flag_clear: assert property (
    req_i.valid &&
    ((req_i.op == iord_pkg::iord_memory_write &&
      req_i.addr == `IORD_TIMER0_EVENT_FLAGS) ||
     (req_i.op == iord_pkg::iord_port_write &&
      req_i.addr == (`IORD_TIMER0_EVENT_FLAGS - `IORD_IO_OFFSET)))
    |=> (mem_q[`IORD_TIMER0_EVENT_FLAGS] & $past(req_i.wdata) &
         ~$past(events_i.timer0)) == `IORD_NONE)
    else $error("flag not cleared by written one");

  // A written zero clears none of the flags
  a_flag_zero_keep: assert property (
    req_i.valid && req_i.wdata == `IORD_NONE &&
    ((req_i.op == iord_pkg::iord_memory_write &&
      req_i.addr == `IORD_TIMER0_EVENT_FLAGS) ||
     (req_i.op == iord_pkg::iord_port_write &&
      req_i.addr == (`IORD_TIMER0_EVENT_FLAGS - `IORD_IO_OFFSET)))
    |=> ($past(mem_q[`IORD_TIMER0_EVENT_FLAGS]) &
         ~mem_q[`IORD_TIMER0_EVENT_FLAGS]) == `IORD_NONE)
    else $error("zero write cleared a flag");

  a_bit_isolate: assert property (
    req_i.valid && req_i.op == iord_pkg::iord_bit_set_op &&
    ea == `IORD_TIMER0_EVENT_FLAGS && ea_ok
    |=> ($past(mem_q[`IORD_TIMER0_EVENT_FLAGS]) & ~$past(wbits) &
         ~mem_q[`IORD_TIMER0_EVENT_FLAGS]) == `IORD_NONE)
    else $error("bit op cleared a neighbouring flag");

  a_port_mirror: assert property (
    req_i.valid && req_i.op == iord_pkg::iord_port_write &&
    req_i.addr == (`IORD_SCRATCH_ONE - `IORD_IO_OFFSET)
    |=> mem_q[`IORD_SCRATCH_ONE] == $past(req_i.wdata))
    else $error("port write missed its mirror address");

  a_port_limit: assert property (
    req_i.valid && !is_wr && req_i.op == iord_pkg::iord_port_read &&
    req_i.addr > `IORD_PORT_TOP
    |=> resp_q.refused && resp_q.rdata == `IORD_NONE)
    else $error("port read beyond 64 locations answered");

  a_ext_mem_only: assert property (
    req_i.valid && req_i.op == iord_pkg::iord_memory_read &&
    req_i.addr >= `IORD_EXT_BASE
    |=> !resp_q.refused && resp_q.ack)
    else $error("extended load refused");

  // Set or clear on the bit-addressable scratch byte moves one bit;
  // the expected byte is rebuilt from the request, not from wbits
  a_scratch_bit: assert property (
    req_i.valid && is_bit &&
    req_i.addr == (`IORD_SCRATCH_ZERO - `IORD_IO_OFFSET)
    |=> mem_q[`IORD_SCRATCH_ZERO] ==
        (($past(req_i.op) == iord_pkg::iord_bit_set_op) ?
         ($past(mem_q[`IORD_SCRATCH_ZERO]) |
          (`IORD_ONE_HOT << $past(req_i.bit_sel))) :
         ($past(mem_q[`IORD_SCRATCH_ZERO]) &
          ~(`IORD_ONE_HOT << $past(req_i.bit_sel)))))
    else $error("scratch bit set wrong");

  a_reserved_zero: assert property (
    req_i.valid && !is_wr && ea_ok && reg_mask(ea) == `IORD_NONE
    |=> resp_q.rdata == `IORD_NONE)
    else $error("reserved location read nonzero");

  // Port and bit forms stop short of the extended range
  a_ext_no_port: assert property (
    req_i.valid && req_i.op != iord_pkg::iord_memory_read &&
    req_i.op != iord_pkg::iord_memory_write &&
    req_i.addr >= (`IORD_EXT_BASE - `IORD_IO_OFFSET)
    |=> resp_q.refused && resp_q.rdata == `IORD_NONE)
    else $error("extended register reached by a port or bit form");

  // Loads and stores below the mirror base belong to the core itself
  a_mem_low: assert property (
    req_i.valid && req_i.addr < `IORD_IO_OFFSET &&
    (req_i.op == iord_pkg::iord_memory_read ||
     req_i.op == iord_pkg::iord_memory_write)
    |=> resp_q.refused && resp_q.rdata == `IORD_NONE)
    else $error("load or store below the mirror base answered");

  // Every request gets exactly one answer, one cycle later
  a_ack_follow: assert property (
    req_i.valid |=> resp_q.ack ##1 (resp_q.ack == $past(req_i.valid)))
    else $error("answer not one cycle after request");

  c_bit_set: cover property (
    req_i.valid && req_i.op == iord_pkg::iord_bit_set_op && ea_ok);
  c_skip_taken: cover property (resp_q.skip);
  c_flag_race: cover property (
    wr_go && ea == `IORD_TIMER0_EVENT_FLAGS && events_i.timer0[0]);
  c_refused: cover property (resp_q.refused);

endmodule // iord_top

// File: sim/iord_core_model.sv
`timescale 1ns/1ps
module iord_core_model (
  // Clock
  input  wire logic                 clk_i,
  // Answer from the decoder
  input  wire iord_pkg::iord_resp_s resp_i,
  // Request towards the decoder
  output      iord_pkg::iord_req_s  req_o
);
  // Idle from time zero so nothing is taken during reset
  initial req_o = '0;

  // Data-space places with no register behind them
  function automatic logic hole(input logic [7:0] a);
    hole = a inside {[8'h00:8'h22], [8'h2C:8'h34], [8'h38:8'h3A], 8'h49,
                     8'h4F, 8'h51, 8'h52, 8'h56, [8'h58:8'h5E], 8'h62,
                     8'h63, 8'h65, 8'h67, 8'h6A, [8'h70:8'hFF]};
  endfunction

  // Implemented bits of the few registers with unused positions we know
  function automatic logic [7:0] impl(input logic [7:0] a);
    case (a)
      8'h61:                      impl = 8'h8F;
      8'h26, 8'h27, 8'h28, 8'h6C: impl = 8'h7F;
      default:                    impl = 8'hFF;
    endcase
  endfunction

  // One access; called at a falling edge, returns at the next one, so
  // calls chain back to back with valid held high between them
  task automatic access(input iord_pkg::iord_op_e op,
                        input logic [7:0] addr, input logic [2:0] bsel,
                        input logic [7:0] wdata, input logic rogue,
                        output iord_pkg::iord_resp_s resp);
    logic [7:0] daddr;
    logic       wr;
    daddr = (op inside {iord_pkg::iord_memory_read,
                        iord_pkg::iord_memory_write}) ? addr : addr + 8'h20;
    wr = op inside {iord_pkg::iord_port_write, iord_pkg::iord_memory_write,
                    iord_pkg::iord_bit_set_op, iord_pkg::iord_bit_clear_op};
    if (wr && !rogue && hole(daddr)) begin
      // A well-behaved core simply skips the write
      req_o.valid = 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      resp = '0;
    end else begin
      req_o.valid   = 1'b1;
      req_o.op      = op;
      req_o.addr    = addr;
      req_o.bit_sel = bsel;
      // Unused positions written as zero unless misbehaving on purpose
      req_o.wdata   = rogue ? wdata : wdata & impl(daddr);
      @(posedge clk_i);
      @(negedge clk_i);
      resp = resp_i;
    end
  endtask

  // Drop the request; stale address and data are inverted, op and bit select left standing
  task automatic release_bus;
    req_o.valid = 1'b0;
    req_o.addr  = ~req_o.addr;
    req_o.wdata = ~req_o.wdata;
  endtask
endmodule // iord_core_model

// File: sim/io_register_space_decoder_bench.sv
`timescale 1ns/1ps
module io_register_space_decoder_bench;
  // Short aliases for the access kinds
  localparam iord_pkg::iord_op_e pr = iord_pkg::iord_port_read;
  localparam iord_pkg::iord_op_e pw = iord_pkg::iord_port_write;
  localparam iord_pkg::iord_op_e mr = iord_pkg::iord_memory_read;
  localparam iord_pkg::iord_op_e mw = iord_pkg::iord_memory_write;
  localparam iord_pkg::iord_op_e bs = iord_pkg::iord_bit_set_op;
  localparam iord_pkg::iord_op_e bc = iord_pkg::iord_bit_clear_op;
  localparam iord_pkg::iord_op_e sh = iord_pkg::iord_skip_when_bit_high;
  localparam iord_pkg::iord_op_e sl = iord_pkg::iord_skip_when_bit_low;

  // One case: request, timer event, expected refusal, skip and data
  typedef struct packed {
    iord_pkg::iord_op_e op;
    logic [7:0]         addr;
    logic [2:0]         bsel;
    logic [7:0]         wd;
    logic               rogue;
    logic [7:0]         evt;
    logic               refd;
    logic               skip;
    logic [7:0]         rd;
  } iord_row_s;

  logic                 clk;        // System clock
  logic                 reset;      // Asynchronous reset
  iord_pkg::iord_req_s  req;        // Driven by the core model
  iord_pkg::iord_evt_s  events;     // Flag set requests
  iord_pkg::iord_pins_s pins;       // Pin levels
  iord_pkg::iord_resp_s resp;       // Decoder answer
  iord_pkg::iord_resp_s r;          // Answer captured by the model
  iord_pkg::iord_gpio_s gpio;       // Port registers
  int                   n_mismatch; // Failed comparisons
  int                   n_tests;    // All comparisons

  // Ordinary cases, run back to back
  iord_row_s rows [$] = '{
    '{pw,8'h0B,3'h0,8'h5A,0,8'h00,0,0,8'h00},
    '{mr,8'h2B,3'h0,8'h00,0,8'h00,0,0,8'h5A},
    '{pr,8'h0B,3'h0,8'h00,0,8'h00,0,0,8'h5A},
    '{sh,8'h0B,3'h1,8'h00,0,8'h00,0,1,8'h5A},
    '{sl,8'h0B,3'h1,8'h00,0,8'h00,0,0,8'h5A},
    '{sl,8'h0B,3'h0,8'h00,0,8'h00,0,1,8'h5A},
    '{sh,8'h0B,3'h0,8'h00,0,8'h00,0,0,8'h5A},
    '{bs,8'h0B,3'h0,8'h00,0,8'h00,0,0,8'h00},
    '{bc,8'h0B,3'h6,8'h00,0,8'h00,0,0,8'h00},
    '{mr,8'h2B,3'h0,8'h00,0,8'h00,0,0,8'h1B},
    '{bs,8'h20,3'h0,8'h00,0,8'h00,1,0,8'h00},
    '{sl,8'h20,3'h0,8'h00,0,8'h00,1,0,8'h00},
    '{pr,8'h40,3'h0,8'h00,0,8'h00,1,0,8'h00},
    '{pw,8'h40,3'h0,8'hFF,0,8'h00,1,0,8'h00},
    '{mr,8'h1F,3'h0,8'h00,0,8'h00,1,0,8'h00},
    '{mw,8'h1F,3'h0,8'hFF,1,8'h00,1,0,8'h00},
    '{mw,8'h61,3'h0,8'hFF,1,8'h00,0,0,8'h00},
    '{mr,8'h61,3'h0,8'h00,0,8'h00,0,0,8'h8F},
    '{pw,8'h3F,3'h0,8'h81,0,8'h00,0,0,8'h00},
    '{mr,8'h5F,3'h0,8'h00,0,8'h00,0,0,8'h81},
    '{bs,8'h1F,3'h5,8'h00,0,8'h00,0,0,8'h00},
    '{pr,8'h1F,3'h0,8'h00,0,8'h00,0,0,8'h20},
    '{pw,8'h1E,3'h0,8'hA5,0,8'h00,0,0,8'h00},
    '{bc,8'h1E,3'h0,8'h00,0,8'h00,0,0,8'h00},
    '{mr,8'h3E,3'h0,8'h00,0,8'h00,0,0,8'hA4},
    '{pw,8'h2A,3'h0,8'h3C,0,8'h00,0,0,8'h00},
    '{mr,8'h4A,3'h0,8'h00,0,8'h00,0,0,8'h3C},
    '{mw,8'h4B,3'h0,8'hC3,0,8'h00,0,0,8'h00},
    '{pr,8'h2B,3'h0,8'h00,0,8'h00,0,0,8'hC3},
    '{mw,8'h62,3'h0,8'hFF,1,8'h00,0,0,8'h00},
    '{mr,8'h62,3'h0,8'h00,0,8'h00,0,0,8'h00},
    '{pw,8'h00,3'h0,8'hFF,1,8'h00,0,0,8'h00},
    '{pr,8'h00,3'h0,8'h00,0,8'h07,0,0,8'h00},
    '{pr,8'h15,3'h0,8'h00,0,8'h00,0,0,8'h07},
    '{pw,8'h15,3'h0,8'h02,0,8'h00,0,0,8'h00},
    '{pr,8'h15,3'h0,8'h00,0,8'h00,0,0,8'h05},
    '{pw,8'h15,3'h0,8'h00,0,8'h00,0,0,8'h00},
    '{pr,8'h15,3'h0,8'h00,0,8'h00,0,0,8'h05},
    '{bs,8'h15,3'h0,8'h00,0,8'h00,0,0,8'h00},
    '{pr,8'h15,3'h0,8'h00,0,8'h00,0,0,8'h04},
    '{bc,8'h15,3'h2,8'h00,0,8'h00,0,0,8'h00},
    '{pr,8'h15,3'h0,8'h00,0,8'h00,0,0,8'h04},
    '{pw,8'h15,3'h0,8'h04,0,8'h04,0,0,8'h00},
    '{pr,8'h15,3'h0,8'h00,0,8'h00,0,0,8'h04},
    '{pr,8'h03,3'h0,8'h00,0,8'h00,0,0,8'h96},
    '{pr,8'h06,3'h0,8'h00,0,8'h00,0,0,8'h7F},
    '{mr,8'h29,3'h0,8'h00,0,8'h00,0,0,8'h3C},
    '{pw,8'h03,3'h0,8'h00,0,8'h00,0,0,8'h00},
    '{pr,8'h03,3'h0,8'h00,0,8'h00,0,0,8'h96},
    '{pw,8'h05,3'h0,8'hAA,0,8'h00,0,0,8'h00},
    '{pw,8'h04,3'h0,8'h55,0,8'h00,0,0,8'h00},
    '{pw,8'h0A,3'h0,8'h0F,0,8'h00,0,0,8'h00}};

  // Decoder under test and the core that drives it
  iord_top dut (.clk_i(clk), .reset_i(reset), .req_i(req),
                .events_i(events), .pins_i(pins), .resp_o(resp),
                .gpio_o(gpio));
  iord_core_model core (.clk_i(clk), .resp_i(resp), .req_o(req));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Value comparison; widths below 48 are zero-extended
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the 64 or so cycles the run needs
  initial begin
    #25000;
    n_mismatch++;
    finish_test();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    n_tests    = 0;
    reset      = 1'b1;
    events     = '0;
    pins       = '{b: 8'h96, c: 8'hFF, d: 8'h3C};
    repeat (5) @(negedge clk);
    cmp(gpio, 48'h0000_0000_0000); // RESET
    cmp(resp, 11'h000); // RESET
    reset = 1'b0;
    // Table of ordinary cases, first one on the first edge after release
    for (int i = 0; i < rows.size(); i++) begin
      events.timer0 = rows[i].evt;
      core.access(rows[i].op, rows[i].addr, rows[i].bsel, rows[i].wd,
                  rows[i].rogue, r);
      cmp(r.ack, 1'b1);
      cmp(r.refused, rows[i].refd);
      cmp(r.skip, rows[i].skip);
      cmp(r.rdata, rows[i].rd);
    end
    core.release_bus();
    // Port outputs follow the writes made above
    cmp(gpio, 48'hAA55_0000_1B0F);
    // Reset in mid-run clears everything
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    cmp(gpio, 48'h0000_0000_0000); // RESET
    cmp(resp, 11'h000); // RESET
    reset = 1'b0;
    core.access(mr, 8'h2B, 3'h0, 8'h00, 1'b0, r);
    cmp(r.rdata, 8'h00); // RESET
    core.access(pr, 8'h03, 3'h0, 8'h00, 1'b0, r);
    cmp(r.rdata, 8'h96); // RESET
    core.release_bus();
    repeat (2) @(negedge clk);
    finish_test();
  end
endmodule // io_register_space_decoder_bench
